//--- core/sad_decoder.sv
// System address decoder: bank routing, internal memory decode and remap.
`timescale 1ns/100ps

module sad_decoder (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire logic [sad_pkg::ADDR_W-1:0] req_addr,
  input wire logic remap_cmd,
  input wire logic boot_select_pin,
  input wire logic cs1_sdram_en,
  input wire logic cs3_nand_en,
  output logic resp_valid,
  output logic sel_rom,
  output logic sel_sram,
  output logic sel_apb,
  output logic abort_err,
  output logic ext_select_0,
  output logic ext_select_1,
  output logic ext_select_2,
  output logic ext_select_3,
  output logic ext_select_4,
  output logic ext_select_5,
  output logic sdram_select,
  output logic nand_select,
  output logic [sad_pkg::EXT_AW-1:0] ext_addr,
  output logic [sad_pkg::LOCAL_W-1:0] local_addr,
  output logic remap_done
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  sad_pkg::sad_target_e bank_tgt;
  logic [sad_pkg::EXT_IDX_W-1:0] bank_ext_idx;
  logic [sad_pkg::AREA_W-1:0] area;
  logic remap_ff;
  logic boot_meta_ff;
  logic boot_sync_ff;
  logic resp_valid_ff;
  logic rom_ff;
  logic sram_ff;
  logic apb_ff;
  logic abort_ff;
  logic sdram_ff;
  logic nand_ff;
  logic [sad_pkg::EXT_CS_NUM-1:0] ext_ff;
  logic [sad_pkg::EXT_AW-1:0] ext_addr_ff;
  logic [sad_pkg::LOCAL_W-1:0] local_ff;
  logic nxt_rom;
  logic nxt_sram;
  logic nxt_apb;
  logic nxt_abort;
  logic nxt_sdram;
  logic nxt_nand;
  logic [sad_pkg::EXT_CS_NUM-1:0] nxt_ext;
  logic [sad_pkg::LOCAL_W-1:0] nxt_local;

  // True when the offset inside a 1-Mbyte area falls within the SRAM.
  function automatic logic sram_hit(input logic [sad_pkg::ADDR_W-1:0] a);
    sram_hit = (a[sad_pkg::AREA_LSB-1:sad_pkg::SRAM_AW] == '0);
  endfunction : sram_hit

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // ****************************************************************
  // First-level decode
  // ****************************************************************
  sad_bank_decode u_bank (
    .bank(req_addr[sad_pkg::BANK_MSB:sad_pkg::BANK_LSB]),
    .target(bank_tgt),
    .ext_idx(bank_ext_idx)
  );

  // ****************************************************************
  // Boot select synchroniser
  // ****************************************************************
  // The pin is a strap from outside the clock domain, so it is sampled twice.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      boot_meta_ff <= sad_pkg::BOOT_RST;
      boot_sync_ff <= sad_pkg::BOOT_RST;
    end else if (clk_en) begin
      boot_meta_ff <= boot_select_pin;
      boot_sync_ff <= boot_meta_ff;
    end
  end

  // ****************************************************************
  // Remap state
  // ****************************************************************
  // A command seen together with a request affects only later requests.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      remap_ff <= sad_pkg::REMAP_RST;
    end else if (clk_en && remap_cmd) begin
      remap_ff <= 1'b1;
    end
  end

  // ****************************************************************
  // Second-level decode and chip select steering
  // ****************************************************************
  always_comb begin
    nxt_rom = 1'b0;
    nxt_sram = 1'b0;
    nxt_apb = 1'b0;
    nxt_abort = 1'b0;
    nxt_sdram = 1'b0;
    nxt_nand = 1'b0;
    nxt_ext = '0;
    nxt_local = '0;
    area = req_addr[sad_pkg::AREA_MSB:sad_pkg::AREA_LSB];
    unique case (bank_tgt)
      sad_pkg::TGT_INT: begin
        nxt_local = {{sad_pkg::AREA_W{1'b0}}, req_addr[sad_pkg::AREA_LSB-1:0]};
        if (area == sad_pkg::AREA_BOOT) begin
          if (remap_ff) begin
            nxt_sram = sram_hit(req_addr);
            nxt_abort = !sram_hit(req_addr);
          end else if (boot_sync_ff) begin
            nxt_rom = 1'b1;
          end else begin
            nxt_ext[sad_pkg::CS_BOOT] = 1'b1;
          end
        end else if (area == sad_pkg::AREA_ROM) begin
          nxt_rom = 1'b1;
        end else if (area == sad_pkg::AREA_SRAM && sram_hit(req_addr)) begin
          nxt_sram = 1'b1;
        end else begin
          nxt_abort = 1'b1;
        end
      end
      sad_pkg::TGT_EXT: begin
        nxt_ext[bank_ext_idx] = 1'b1;
        if (bank_ext_idx == sad_pkg::CS_SDRAM && cs1_sdram_en) begin
          nxt_ext[bank_ext_idx] = 1'b0;
          nxt_sdram = 1'b1;
        end
        nxt_nand = (bank_ext_idx == sad_pkg::CS_NAND) && cs3_nand_en;
      end
      sad_pkg::TGT_APB: begin
        nxt_apb = 1'b1;
        nxt_local = req_addr[sad_pkg::LOCAL_W-1:0];
      end
      sad_pkg::TGT_NONE: begin
        nxt_abort = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // Answer registers
  // ****************************************************************
  // Selects last one enabled cycle per taken request, so enabled idle cycles show none; a low clk_en holds them.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      resp_valid_ff <= 1'b0;
      rom_ff <= 1'b0;
      sram_ff <= 1'b0;
      apb_ff <= 1'b0;
      abort_ff <= 1'b0;
      sdram_ff <= 1'b0;
      nand_ff <= 1'b0;
      ext_ff <= '0;
    end else if (clk_en) begin
      resp_valid_ff <= req_valid;
      rom_ff <= req_valid && nxt_rom;
      sram_ff <= req_valid && nxt_sram;
      apb_ff <= req_valid && nxt_apb;
      abort_ff <= req_valid && nxt_abort;
      sdram_ff <= req_valid && nxt_sdram;
      nand_ff <= req_valid && nxt_nand;
      ext_ff <= req_valid ? nxt_ext : '0;
    end
  end

  // Addresses hold between requests; only the selects say they are live.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ext_addr_ff <= '0;
      local_ff <= '0;
    end else if (clk_en && req_valid) begin
      ext_addr_ff <= req_addr[sad_pkg::EXT_AW-1:0];
      local_ff <= nxt_local;
    end
  end

  assign resp_valid = resp_valid_ff;
  assign sel_rom = rom_ff;
  assign sel_sram = sram_ff;
  assign sel_apb = apb_ff;
  assign abort_err = abort_ff;
  assign sdram_select = sdram_ff;
  assign nand_select = nand_ff;
  assign ext_select_0 = ext_ff[0];
  assign ext_select_1 = ext_ff[1];
  assign ext_select_2 = ext_ff[2];
  assign ext_select_3 = ext_ff[3];
  assign ext_select_4 = ext_ff[4];
  assign ext_select_5 = ext_ff[5];
  assign ext_addr = ext_addr_ff;
  assign local_addr = local_ff;
  assign remap_done = remap_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence take_s;
    clk_en && req_valid;
  endsequence

  sequence remap_taken_s;
    clk_en && remap_cmd;
  endsequence

  sequence zero_sram_req_s;
    take_s ##0 (req_addr[sad_pkg::BANK_MSB:sad_pkg::AREA_LSB] == '0) ##0 sram_hit(req_addr);
  endsequence

  single_target_a: assert property (
    resp_valid |-> $onehot({sel_rom, sel_sram, sel_apb, abort_err, sdram_select, ext_ff}))
    else $error("answer does not name exactly one target");

  ext_bank_cs_a: assert property (
    take_s ##0 (bank_tgt == sad_pkg::TGT_EXT) ##0 !(bank_ext_idx == sad_pkg::CS_SDRAM
      && cs1_sdram_en) |=> ext_ff == (6'h01 << $past(bank_ext_idx)))
    else $error("external bank raised the wrong chip select");

  int_bank_route_a: assert property (
    take_s ##0 (req_addr[sad_pkg::BANK_MSB:sad_pkg::BANK_LSB] == sad_pkg::BANK_INT)
      ##0 (remap_ff || boot_sync_ff) |=> sel_rom || sel_sram || abort_err)
    else $error("bank 0 access left the internal memories");

  periph_bank_a: assert property (
    take_s ##0 (req_addr[sad_pkg::BANK_MSB:sad_pkg::BANK_LSB] == sad_pkg::BANK_PERIPH)
      |=> sel_apb && local_addr == $past(req_addr[sad_pkg::LOCAL_W-1:0]))
    else $error("peripheral bank not sent to the bridge");

  unused_abort_a: assert property (
    take_s ##0 (req_addr[sad_pkg::BANK_MSB:sad_pkg::BANK_LSB] > sad_pkg::BANK_EXT_LAST)
      ##0 (req_addr[sad_pkg::BANK_MSB:sad_pkg::BANK_LSB] < sad_pkg::BANK_PERIPH)
      |=> abort_err && resp_valid)
    else $error("unused bank did not abort");

  sram_fixed_a: assert property (
    take_s ##0 (req_addr[sad_pkg::ADDR_W-1:sad_pkg::AREA_LSB]
      == sad_pkg::SRAM_BASE[sad_pkg::ADDR_W-1:sad_pkg::AREA_LSB])
      |=> sel_sram == $past(sram_hit(req_addr)))
    else $error("SRAM base area decoded wrongly");

  zero_before_remap_a: assert property (
    take_s ##0 !remap_ff ##0 (req_addr[sad_pkg::BANK_MSB:sad_pkg::AREA_LSB] == '0) |=> !sel_sram)
    else $error("SRAM answered at zero before remap");

  zero_after_remap_a: assert property (
    remap_taken_s ##1 zero_sram_req_s |=> sel_sram && !sel_rom)
    else $error("SRAM missing at zero after remap");

  rom_fixed_a: assert property (
    take_s ##0 (req_addr[sad_pkg::ADDR_W-1:sad_pkg::AREA_LSB]
      == sad_pkg::ROM_BASE[sad_pkg::ADDR_W-1:sad_pkg::AREA_LSB]) |=> sel_rom)
    else $error("ROM missing at its fixed base");

  rom_mirror_a: assert property (
    take_s ##0 !remap_ff ##0 boot_sync_ff ##0
      (req_addr[sad_pkg::BANK_MSB:sad_pkg::AREA_LSB] == '0) |=> sel_rom)
    else $error("ROM not mirrored at zero");

  ext_addr_pass_a: assert property (
    take_s |=> ext_addr == $past(req_addr[sad_pkg::EXT_AW-1:0]))
    else $error("external address not carried");

  sdram_swap_a: assert property (
    take_s ##0 (bank_tgt == sad_pkg::TGT_EXT) ##0 (bank_ext_idx == sad_pkg::CS_SDRAM)
      |=> sdram_select == $past(cs1_sdram_en) && ext_select_1 == !$past(cs1_sdram_en))
    else $error("chip select 1 steering wrong");

  nand_flag_a: assert property (
    nand_select |-> ext_select_3 && resp_valid)
    else $error("NAND flag without chip select 3");

  remap_sticky_a: assert property (
    remap_taken_s |=> remap_done [*8])
    else $error("remap state did not stick");

  boot_cs0_a: assert property (
    take_s ##0 !remap_ff ##0 !boot_sync_ff ##0
      (req_addr[sad_pkg::BANK_MSB:sad_pkg::AREA_LSB] == '0) |=> ext_select_0 && !sel_rom)
    else $error("zero not routed to chip select 0");

endmodule : sad_decoder

//--- core/sad_pkg.sv
// Constants and types shared by the system address decoder.
package sad_pkg;

  // ****************************************************************
  // Address layout
  // ****************************************************************
  localparam int ADDR_W = 32;
  localparam int BANK_MSB = 31;
  localparam int BANK_LSB = 28;
  localparam int BANK_W = BANK_MSB - BANK_LSB + 1;
  localparam int AREA_MSB = 27;
  localparam int AREA_LSB = 20;
  localparam int AREA_W = AREA_MSB - AREA_LSB + 1;
  localparam int LOCAL_W = BANK_LSB;
  localparam int EXT_AW = 26;
  localparam int EXT_CS_NUM = 6;
  localparam int EXT_IDX_W = 3;

  // ****************************************************************
  // Bank and area codes
  // ****************************************************************
  localparam logic [BANK_W-1:0] BANK_INT = 4'h0;
  localparam logic [BANK_W-1:0] BANK_EXT_FIRST = 4'h1;
  localparam logic [BANK_W-1:0] BANK_EXT_LAST = 4'h6;
  localparam logic [BANK_W-1:0] BANK_PERIPH = 4'hF;
  localparam logic [AREA_W-1:0] AREA_BOOT = 8'h00;
  localparam logic [AREA_W-1:0] AREA_ROM = 8'h01;
  localparam logic [AREA_W-1:0] AREA_SRAM = 8'h03;
  localparam logic [ADDR_W-1:0] ROM_BASE = 32'h0010_0000;
  localparam logic [ADDR_W-1:0] SRAM_BASE = 32'h0030_0000;

  // ****************************************************************
  // Internal memory sizes
  // ****************************************************************
  localparam int SRAM_BYTES = 32768;
  localparam int SRAM_AW = $clog2(SRAM_BYTES);

  // ****************************************************************
  // Chip select numbers and reset values
  // ****************************************************************
  localparam int CS_BOOT = 0;
  localparam logic [EXT_IDX_W-1:0] CS_SDRAM = 3'h1;
  localparam logic [EXT_IDX_W-1:0] CS_NAND = 3'h3;
  localparam logic REMAP_RST = 1'b0;
  localparam logic BOOT_RST = 1'b0;

  typedef enum logic [1:0] {
    TGT_INT,
    TGT_EXT,
    TGT_APB,
    TGT_NONE
  } sad_target_e;

endpackage : sad_pkg

//--- core/sad_bank_decode.sv
// First-level bank decode of the system address decoder.
`timescale 1ns/100ps
module sad_bank_decode (
  input wire logic [sad_pkg::BANK_W-1:0] bank,
  output sad_pkg::sad_target_e target,
  output logic [sad_pkg::EXT_IDX_W-1:0] ext_idx
);

  // ****************************************************************
  // Bank classification
  // ****************************************************************
  logic [sad_pkg::BANK_W-1:0] ext_off;

  // Sixteen banks come straight from the top nibble.
  always_comb begin
    ext_off = bank - sad_pkg::BANK_EXT_FIRST;
    ext_idx = ext_off[sad_pkg::EXT_IDX_W-1:0];
    if (bank == sad_pkg::BANK_INT) begin
      target = sad_pkg::TGT_INT;
    end else if (bank >= sad_pkg::BANK_EXT_FIRST && bank <= sad_pkg::BANK_EXT_LAST) begin
      target = sad_pkg::TGT_EXT;
    end else if (bank == sad_pkg::BANK_PERIPH) begin
      target = sad_pkg::TGT_APB;
    end else begin
      target = sad_pkg::TGT_NONE;
    end
  end

endmodule : sad_bank_decode

//--- test/sad_target_mon.sv
// Downstream target model: reports which target took each answer.
`timescale 1ns/100ps
module sad_target_mon (
  input wire logic sel_rom,
  input wire logic sel_sram,
  input wire logic sel_apb,
  input wire logic abort_err,
  input wire logic ext_select_0,
  input wire logic ext_select_1,
  input wire logic ext_select_2,
  input wire logic ext_select_3,
  input wire logic ext_select_4,
  input wire logic ext_select_5,
  input wire logic sdram_select,
  output logic [3:0] code,
  output logic [3:0] n_hot
);
  // ****************************************************************
  // Target encoding
  // ****************************************************************
  // Every strobe but nand_select is counted, so a stray second select cannot hide.
  logic [10:0] hits;
  assign hits = {sdram_select, ext_select_5, ext_select_4, ext_select_3, ext_select_2,
    ext_select_1, ext_select_0, abort_err, sel_apb, sel_sram, sel_rom};
  always_comb begin
    code = 4'hF;
    n_hot = 4'h0;
    for (int i = 0; i < 11; i++) begin
      if (hits[i]) begin
        code = i[3:0];
        n_hot = n_hot + 4'h1;
      end
    end
  end
endmodule : sad_target_mon

//--- test/sad_decoder_tb_top.sv
// Self-checking testbench of the system address decoder.
`timescale 1ns/100ps
module sad_decoder_tb_top;
  logic sys_clk, nrst, clk_en, req_valid, remap_cmd, boot_select_pin;
  logic cs1_sdram_en, cs3_nand_en, resp_valid, sel_rom, sel_sram, sel_apb, abort_err;
  logic ext_select_0, ext_select_1, ext_select_2, ext_select_3, ext_select_4;
  logic ext_select_5, sdram_select, nand_select, remap_done;
  logic [31:0] req_addr;
  logic [25:0] ext_addr;
  logic [27:0] local_addr;
  logic [3:0] code, n_hot;
  int miscompares, n_compared, seed, cyc;
  bit m_remap;
  int exp_q[$];

  sad_decoder i_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .req_valid(req_valid),
    .req_addr(req_addr), .remap_cmd(remap_cmd), .boot_select_pin(boot_select_pin),
    .cs1_sdram_en(cs1_sdram_en), .cs3_nand_en(cs3_nand_en), .resp_valid(resp_valid),
    .sel_rom(sel_rom), .sel_sram(sel_sram), .sel_apb(sel_apb), .abort_err(abort_err),
    .ext_select_0(ext_select_0), .ext_select_1(ext_select_1), .ext_select_2(ext_select_2),
    .ext_select_3(ext_select_3), .ext_select_4(ext_select_4), .ext_select_5(ext_select_5),
    .sdram_select(sdram_select), .nand_select(nand_select), .ext_addr(ext_addr),
    .local_addr(local_addr), .remap_done(remap_done));

  sad_target_mon i_mon (.sel_rom(sel_rom), .sel_sram(sel_sram), .sel_apb(sel_apb),
    .abort_err(abort_err), .ext_select_0(ext_select_0), .ext_select_1(ext_select_1),
    .ext_select_2(ext_select_2), .ext_select_3(ext_select_3), .ext_select_4(ext_select_4),
    .ext_select_5(ext_select_5), .sdram_select(sdram_select), .code(code), .n_hot(n_hot));

  // ****************************************************************
  // Clock, watchdog and reporting
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 100000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step

  // ****************************************************************
  // Reference model
  // ****************************************************************
  // Codes: 0 ROM, 1 SRAM, 2 bridge, 3 abort, 4 to 9 external 0 to 5, 10 SDRAM.
  function automatic int exp_code(logic [31:0] a, bit rm, bit bt, bit c1);
    int bank;
    bit ok;
    bank = a[31:28];
    ok = (a[19:15] == 5'h00);
    if (bank == 0) begin
      if (a[27:20] == 8'h00) return rm ? (ok ? 1 : 3) : (bt ? 0 : 4);
      if (a[27:20] == 8'h01) return 0;
      if (a[27:20] == 8'h03) return ok ? 1 : 3;
      return 3;
    end
    if (bank >= 1 && bank <= 6) return (bank == 2 && c1) ? 10 : bank + 3;
    return (bank == 15) ? 2 : 3;
  endfunction : exp_code

  function automatic logic [31:0] rnd_addr();
    logic [31:0] a;
    a = $random(seed);
    if (a[3:0] < 4'h8) a[31:28] = 4'h0;
    if (!a[6]) a[27:20] = a[4] ? 8'h03 : {7'h00, a[5]};
    if (a[7]) a[19:15] = 5'h00;
    return a;
  endfunction : rnd_addr

  // ****************************************************************
  // Drivers
  // ****************************************************************
  task automatic issue(input logic [31:0] a, input bit cmd);
    int e;
    e = exp_code(a, m_remap, boot_select_pin, cs1_sdram_en);
    exp_q.push_back(e);
    req_valid = 1'b1;
    req_addr = a;
    remap_cmd = cmd;
    step();
    if (cmd) m_remap = 1'b1;
    check("resp_valid", resp_valid, 1);
    check("target", code, exp_q.pop_front());
    check("hot count", n_hot, 1);
    check("ext_addr", ext_addr, a[25:0]);
    check("local_addr", local_addr, a[31:28] == 4'hF ? {4'h0, a[27:0]} :
      (a[31:28] == 4'h0 ? {12'h000, a[19:0]} : 32'h0000_0000));
    check("nand_select", nand_select, e == 7 && cs3_nand_en);
    check("remap_done", remap_done, m_remap);
  endtask : issue

  task automatic idle();
    req_valid = 1'b0;
    remap_cmd = 1'b0;
    step();
    check("idle resp", resp_valid, 0);
    check("idle selects", n_hot, 0);
  endtask : idle

  task automatic do_reset(input int n);
    nrst = 1'b0;
    req_valid = 1'b0;
    repeat (n) step();
    nrst = 1'b1;
    m_remap = 1'b0;
    check("reset remap", remap_done, 0);
  endtask : do_reset

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    req_valid = 1'b0;
    req_addr = 32'h0000_0000;
    remap_cmd = 1'b0;
    boot_select_pin = 1'b0;
    cs1_sdram_en = 1'b0;
    cs3_nand_en = 1'b0;
    seed = 51;
    do_reset(20);
    repeat (3) idle();
    issue(32'h0000_0040, 1'b0);
    issue(32'h0010_0000, 1'b0);
    issue(32'h0030_7FFC, 1'b0);
    issue(32'h0030_8000, 1'b0);
    issue(32'h0020_0000, 1'b0);
    issue(32'h0FFF_FFFF, 1'b0);
    issue(32'h6FFF_FFFC, 1'b0);
    for (int b = 0; b < 16; b++) issue({b[3:0], 28'h0123456}, 1'b0);
    for (int k = 0; k < 4; k++) begin
      {cs1_sdram_en, cs3_nand_en} = k[1:0];
      issue(32'h2000_0010, 1'b0);
      issue(32'h4000_0010, 1'b0);
    end
    issue(32'hF000_1000, 1'b0);
    // Freezing the clock enable must hold the answer rather than drop it.
    req_valid = 1'b0;
    clk_en = 1'b0;
    repeat (2) step();
    check("frozen target", code, 2);
    check("frozen valid", resp_valid, 1);
    clk_en = 1'b1;
    idle();
    boot_select_pin = 1'b1;
    repeat (3) idle();
    issue(32'h0000_0000, 1'b0);
    for (int i = 0; i < 300; i++) begin
      {cs1_sdram_en, cs3_nand_en} = 2'($random(seed));
      issue(rnd_addr(), 1'b0);
    end
    issue(32'h0000_0100, 1'b1);
    issue(32'h0000_0100, 1'b0);
    issue(32'h0010_0000, 1'b0);
    issue(32'h0030_0100, 1'b0);
    issue(32'h0000_8000, 1'b0);
    for (int i = 0; i < 200; i++) issue(rnd_addr(), 1'($random(seed)));
    repeat (4) idle();
    check("sticky remap", remap_done, 1);
    do_reset(2);
    boot_select_pin = 1'b0;
    repeat (3) idle();
    issue(32'h0000_0000, 1'b0);
    idle();
    tally_and_finish();
  end
endmodule : sad_decoder_tb_top
